// >>> src/cpu_interrupt_controller.sv
// interrupt controller of the core: qualify, flag, mask, arbitrate, vector, acknowledge
`timescale 1ns/1ps
`include "irq_ctrl_defines.svh"

module cpu_interrupt_controller
  import irq_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // external pins, active low
  input  wire logic        ext_irq_one,
  input  wire logic        ext_irq_two,
  input  wire logic        ext_irq_three,
  input  wire logic        ext_irq_four,
  input  wire logic        nmi_in_n,
  // on-chip peripheral events, one-cycle pulses; serial_port_active is a level held while the port runs
  input  wire logic        timer_irq,
  input  wire logic        serial_rx_irq,
  input  wire logic        serial_tx_irq,
  input  wire logic        second_port_rx_irq,
  input  wire logic        second_port_tx_irq,
  input  wire logic        host_port_irq,
  input  wire logic        serial_port_active,
  // data-space register access
  input  wire logic [15:0] dm_addr,
  input  wire logic        dm_wr,
  input  wire logic        dm_rd,
  input  wire logic [15:0] dm_wdata,
  output logic [15:0]      dm_rdata_r,
  // core state and instructions
  input  wire logic        boundary_ok,
  input  wire logic        deep_idle_state,
  input  wire logic        idle_state,
  input  wire logic        set_disable_instr,
  input  wire logic        clear_disable_instr,
  input  wire logic        enable_return_instr,
  input  wire logic        plain_irq_return_instr,
  input  wire logic        nmi_instr,
  input  wire logic        trap_instr,
  input  wire logic        software_irq_instr,
  input  wire logic [4:0]  software_irq_num,
  input  wire logic        page_ptr_wr,
  input  wire logic [4:0]  page_ptr_wdata,
  // bus hold
  input  wire logic        bus_hold,
  input  wire logic        hold_mode_bit,
  // service outputs
  output logic             global_disable_bit_r,
  output logic [4:0]       vector_page_pointer_r,
  output logic [15:0]      vector_addr_r,
  output logic             vector_load_r,
  output logic             pc_push_r,
  output logic             shadow_save_r,
  output logic             shadow_restore_r,
  output logic             acknowledge_out_n_r,
  output logic [4:0]       ack_addr_r,
  output logic             ack_addr_drive_r,
  output logic             wake_req_r
);

  // ==================================================================
  // pin qualification
  logic [4:0]  pin_vec;
  logic [4:0]  pin_evt;

  assign pin_vec = {nmi_in_n, ext_irq_four, ext_irq_three, ext_irq_two, ext_irq_one};

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_qual
      irq_pulse_qualifier u_qual
      (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .pin_in          (pin_vec[g]),
        .deep_idle_state (deep_idle_state),
        .valid_pulse_r   (pin_evt[g])
      );
    end
  endgenerate

  // ==================================================================
  // flag sources, laid out like the mask
  logic [15:0] flag_set;
  logic [15:0] flag_r;
  logic [15:0] mask_r;
  logic [15:0] eligible;
  logic [15:0] grant;
  logic [4:0]  grant_num;
  logic        grant_any;

  always_comb
  begin
    flag_set                 = 16'h0000;
    flag_set[`BIT_EXT_ONE]   = pin_evt[0];
    flag_set[`BIT_EXT_TWO]   = pin_evt[1];
    flag_set[`BIT_EXT_THREE] = pin_evt[2];
    flag_set[`BIT_TIMER]     = timer_irq;
    flag_set[`BIT_SERIAL_RX] = serial_rx_irq;
    flag_set[`BIT_SERIAL_TX] = serial_tx_irq;
    flag_set[`BIT_SECOND_RX] = second_port_rx_irq;
    flag_set[`BIT_SECOND_TX] = second_port_tx_irq;
    flag_set[`BIT_EXT_FOUR]  = pin_evt[3];
    flag_set[`BIT_HOST_PORT] = host_port_irq;
  end

  assign eligible = flag_r & mask_r;

  irq_priority_pick u_pick
  (
    .req     (eligible),
    .grant   (grant),
    .vec_num (grant_num),
    .any     (grant_any)
  );

  // ==================================================================
  // take decision
  svc_state_t  state_r;
  svc_state_t  state_nxt;
  take_kind_t  kind_r;
  logic [4:0]  svc_num_r;
  logic [15:0] svc_bit_r;
  logic        nmi_pend_r;
  logic        take;
  take_kind_t  take_kind;
  logic [4:0]  take_num;
  logic [15:0] take_bit;
  logic [15:0] soft_bit;

  always_comb
  begin
    soft_bit = 16'h0000;
    if (software_irq_num != 5'h00 && software_irq_num <= 5'h10)
      soft_bit[4'(software_irq_num - 5'h01)] = 1'b1;
  end

  always_comb
  begin
    take      = 1'b0;
    take_kind = KIND_MASKABLE;
    take_num  = `VEC_NUM_RESET;
    take_bit  = 16'h0000;
    if (state_r == ST_IDLE && boundary_ok)
    begin
      // trap instruction first, then nonmaskable (instruction or pin), then the software instruction, then lines
      if (trap_instr)
      begin
        take      = 1'b1;
        take_kind = KIND_TRAP;
        take_num  = `VEC_NUM_TRAP;
      end
      else if (nmi_instr || nmi_pend_r)
      begin
        take      = 1'b1;
        take_kind = KIND_NMI;
        take_num  = `VEC_NUM_NMI;
      end
      else if (software_irq_instr)
      begin
        take      = 1'b1;
        take_kind = KIND_SOFT;
        take_num  = software_irq_num;
        take_bit  = soft_bit & `USED_LINES_MASK;
      end
      else if (!global_disable_bit_r && grant_any)
      begin
        take      = 1'b1;
        take_kind = KIND_MASKABLE;
        take_num  = grant_num;
        take_bit  = grant;
      end
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:   state_nxt = take ? ST_VECTOR : ST_IDLE;
      ST_VECTOR: state_nxt = ST_ACK;
      ST_ACK:    state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r   <= ST_IDLE;
      kind_r    <= KIND_MASKABLE;
      svc_num_r <= `VEC_NUM_RESET;
      svc_bit_r <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      if (take)
      begin
        kind_r    <= take_kind;
        svc_num_r <= take_num;
        svc_bit_r <= take_bit;
      end
    end
  end

  // nonmaskable pin event waits for a boundary; repeats merge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      nmi_pend_r <= 1'b0;
    else if (pin_evt[4])
      nmi_pend_r <= 1'b1;
    else if (take && take_kind == KIND_NMI)
      nmi_pend_r <= 1'b0;
  end

  // ==================================================================
  // flag and mask registers
  logic        wr_flag;
  logic        wr_mask;
  logic [15:0] take_clr;

  assign wr_flag = dm_wr && (dm_addr == `FLAG_REG_ADDR);
  assign wr_mask = dm_wr && (dm_addr == `MASK_REG_ADDR);
  // serial flags stay while the port runs; the port clears them itself
  assign take_clr = (state_r == ST_ACK) ?
    (svc_bit_r & ~(serial_port_active ? `SERIAL_LINES_MASK : 16'h0000)) : 16'h0000;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_r <= `FLAG_RESET;
    else
      // new event wins over any clear in the same cycle
      flag_r <= ((flag_r & ~take_clr & ~(wr_flag ? dm_wdata : 16'h0000)) | flag_set)
                & `USED_LINES_MASK;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_r <= `MASK_RESET;
    else if (wr_mask)
      mask_r <= dm_wdata & `USED_LINES_MASK;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      dm_rdata_r <= 16'h0000;
    else if (dm_rd && dm_addr == `FLAG_REG_ADDR)
      dm_rdata_r <= flag_r;
    else if (dm_rd && dm_addr == `MASK_REG_ADDR)
      dm_rdata_r <= mask_r;
    else
      dm_rdata_r <= 16'h0000;
  end

  // ==================================================================
  // global disable and vector page
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      global_disable_bit_r <= 1'b1;
    else if (take || set_disable_instr)
      global_disable_bit_r <= 1'b1;
    else if (clear_disable_instr || enable_return_instr)
      global_disable_bit_r <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      vector_page_pointer_r <= `VEC_PAGE_RESET;
    else if (page_ptr_wr)
      vector_page_pointer_r <= page_ptr_wdata;
  end

  // ==================================================================
  // service sequence outputs
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vector_addr_r       <= `VEC_ADDR_RESET;
      vector_load_r       <= 1'b0;
      pc_push_r           <= 1'b0;
      shadow_save_r       <= 1'b0;
      acknowledge_out_n_r <= 1'b1;
      ack_addr_r          <= 5'h00;
      ack_addr_drive_r    <= 1'b0;
    end
    else
    begin
      vector_load_r       <= state_r == ST_VECTOR;
      pc_push_r           <= state_r == ST_VECTOR;
      // nonmaskable and trap keep the shadows for the interrupted routine
      shadow_save_r       <= state_r == ST_VECTOR &&
                             (kind_r == KIND_MASKABLE || kind_r == KIND_SOFT);
      // page pointer fills the top bits so each page spans 2K words
      if (state_r == ST_VECTOR)
        vector_addr_r <= {vector_page_pointer_r, 5'h00, svc_num_r, 1'b0};
      acknowledge_out_n_r <= !(state_nxt == ST_ACK);
      if (state_nxt == ST_ACK)
      begin
        ack_addr_r       <= svc_num_r;
        ack_addr_drive_r <= !(bus_hold && !hold_mode_bit);
      end
      else
        ack_addr_drive_r <= 1'b0;
    end
  end

  // ==================================================================
  // returns and idle wake
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shadow_restore_r <= 1'b0;
      wake_req_r       <= 1'b0;
    end
    else
    begin
      shadow_restore_r <= enable_return_instr || plain_irq_return_instr;
      // wake only asks the core to run; flags are left alone
      wake_req_r <= idle_state && ((|eligible) || nmi_pend_r);
    end
  end

  // ==================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_flag_sets;
    timer_irq |=> flag_r[`BIT_TIMER];
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("event lost");

  property p_write_zero;
    wr_flag && dm_wdata == 16'h0000 && state_r != ST_ACK |=>
      (flag_r & $past(flag_r)) == $past(flag_r);
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("zero write cleared");

  property p_unused_zero;
    (flag_r & ~`USED_LINES_MASK) == 16'h0000 && (mask_r & ~`USED_LINES_MASK) == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_ack_shows;
    state_r == ST_ACK |-> !acknowledge_out_n_r && ack_addr_r == svc_num_r &&
      vector_addr_r == {vector_page_pointer_r, 5'h00, svc_num_r, 1'b0};
  endproperty
  a_ack_shows: assert property (p_ack_shows) else $error("ack or vector wrong");

  property p_hold_hides;
    state_r == ST_ACK && $past(bus_hold) && !$past(hold_mode_bit) |-> !ack_addr_drive_r;
  endproperty
  a_hold_hides: assert property (p_hold_hides) else $error("number driven on hold");

  property p_take_disables;
    take |=> global_disable_bit_r ##1 (!acknowledge_out_n_r && vector_load_r);
  endproperty
  a_take_disables: assert property (p_take_disables) else $error("take sequence");

  property p_no_nested;
    state_r == ST_IDLE && global_disable_bit_r && !trap_instr && !nmi_instr &&
      !nmi_pend_r && !software_irq_instr |=> state_r == ST_IDLE;
  endproperty
  a_no_nested: assert property (p_no_nested) else $error("take while disabled");

  property p_flag_cleared;
    state_r == ST_ACK && kind_r == KIND_MASKABLE && !serial_port_active &&
      (flag_set & svc_bit_r) == 16'h0000 |=> (flag_r & svc_bit_r) == 16'h0000;
  endproperty
  a_flag_cleared: assert property (p_flag_cleared) else $error("flag kept");

  property p_return_restores;
    enable_return_instr || plain_irq_return_instr |=> shadow_restore_r;
  endproperty
  a_return_restores: assert property (p_return_restores) else $error("no restore");

  property p_mask_write;
    wr_mask |=> mask_r == ($past(dm_wdata) & `USED_LINES_MASK);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  c_maskable: cover property (take && take_kind == KIND_MASKABLE ##2 !acknowledge_out_n_r);
  c_nmi_pin: cover property (pin_evt[4] ##[1:20] (take && take_kind == KIND_NMI));
  c_hold_ack: cover property (state_r == ST_ACK && !ack_addr_drive_r);
  c_trap: cover property (take && take_kind == KIND_TRAP);

endmodule // cpu_interrupt_controller

// >>> pkg/irq_ctrl_defines.svh
// constants of the interrupt controller: offsets, fields, reset values, counts
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

// ==================================================================
// data-space register offsets
`define MASK_REG_ADDR      16'h0004
`define FLAG_REG_ADDR      16'h0006

// ==================================================================
// flag and mask bit positions
`define BIT_EXT_ONE        0
`define BIT_EXT_TWO        1
`define BIT_EXT_THREE      2
`define BIT_TIMER          3
`define BIT_SERIAL_RX      4
`define BIT_SERIAL_TX      5
`define BIT_SECOND_RX      6
`define BIT_SECOND_TX      7
`define BIT_EXT_FOUR       8
`define BIT_HOST_PORT      11
`define USED_LINES_MASK    16'h09FF
`define SERIAL_LINES_MASK  16'h00F0

// ==================================================================
// vector numbers (vector slot offset is twice the number)
`define VEC_NUM_RESET      5'h00
`define VEC_NUM_TRAP       5'h11
`define VEC_NUM_NMI        5'h12
`define VEC_PAGE_W         5

// ==================================================================
// reset values
`define MASK_RESET         16'h0000
`define FLAG_RESET         16'h0000
`define VEC_PAGE_RESET     5'h00
`define VEC_ADDR_RESET     16'h0000

// ==================================================================
// pulse qualification, in machine cycles
`define QUAL_HIGH_MIN      3'h2
`define QUAL_LOW_MIN       3'h3
`define QUAL_HIGH_MIN_IDLE 3'h4
`define QUAL_LOW_MIN_IDLE  3'h5
`define QUAL_CNT_MAX       3'h7

`endif

// >>> pkg/irq_ctrl_pkg.sv
// types of the interrupt controller
package irq_ctrl_pkg;

  // service sequence states
  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'b00,
    ST_VECTOR = 2'b01,
    ST_ACK    = 2'b10
  } svc_state_t;

  // what started the service sequence
  typedef enum logic [1:0]
  {
    KIND_MASKABLE = 2'b00,
    KIND_SOFT     = 2'b01,
    KIND_NMI      = 2'b10,
    KIND_TRAP     = 2'b11
  } take_kind_t;

endpackage

// >>> src/irq_pulse_qualifier.sv
// qualifies one active-low interrupt pin: high then low for minimum cycle counts
`timescale 1ns/1ps
`include "irq_ctrl_defines.svh"

module irq_pulse_qualifier
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // pin and mode
  input  wire logic pin_in,
  input  wire logic deep_idle_state,
  // qualified event
  output logic      valid_pulse_r
);

  logic [2:0] hi_cnt_r;
  logic [2:0] lo_cnt_r;
  logic       armed_r;
  logic       armed_nxt;
  logic [2:0] lo_nxt;
  logic [2:0] hi_min;
  logic [2:0] lo_min;

  assign hi_min = deep_idle_state ? `QUAL_HIGH_MIN_IDLE : `QUAL_HIGH_MIN;
  assign lo_min = deep_idle_state ? `QUAL_LOW_MIN_IDLE : `QUAL_LOW_MIN;
  // the high phase is judged on the first low cycle, then held
  assign armed_nxt = (hi_cnt_r != 3'h0) ? (hi_cnt_r >= hi_min) : armed_r;
  assign lo_nxt = (lo_cnt_r == `QUAL_CNT_MAX) ? lo_cnt_r : lo_cnt_r + 3'h1;

  // ==================================================================
  // phase counters
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_cnt_r <= 3'h0;
      lo_cnt_r <= 3'h0;
      armed_r  <= 1'b0;
    end
    else if (pin_in)
    begin
      lo_cnt_r <= 3'h0;
      armed_r  <= 1'b0;
      if (lo_cnt_r != 3'h0)
        hi_cnt_r <= 3'h1;
      else if (hi_cnt_r != `QUAL_CNT_MAX)
        hi_cnt_r <= hi_cnt_r + 3'h1;
    end
    else
    begin
      hi_cnt_r <= 3'h0;
      lo_cnt_r <= lo_nxt;
      armed_r  <= armed_nxt && (lo_nxt != lo_min);
    end
  end

  // ==================================================================
  // one event per qualified low phase, however long it lasts
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      valid_pulse_r <= 1'b0;
    else
      valid_pulse_r <= !pin_in && armed_nxt && (lo_nxt == lo_min);
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_normal_shape;
    valid_pulse_r && !$past(deep_idle_state) |->
      !$past(pin_in, 1) && !$past(pin_in, 2) && !$past(pin_in, 3) &&
      $past(pin_in, 4) && $past(pin_in, 5);
  endproperty
  a_normal_shape: assert property (p_normal_shape) else $error("pulse shape too short");

  property p_single_event;
    valid_pulse_r |=> !valid_pulse_r;
  endproperty
  a_single_event: assert property (p_single_event) else $error("double event");

endmodule // irq_pulse_qualifier

// >>> src/irq_priority_pick.sv
// fixed-priority pick: lowest set bit wins, reported as vector number
`timescale 1ns/1ps

module irq_priority_pick
(
  // candidates
  input  wire logic [15:0] req,
  // winner
  output logic [15:0]      grant,
  output logic [4:0]       vec_num,
  output logic             any
);

  logic [15:0] seen;

  // seen[i] tells that a stronger line already asks
  assign seen[0]  = 1'b0;
  assign grant[0] = req[0];
  genvar i;
  generate
    for (i = 1; i < 16; i = i + 1)
    begin : g_chain
      assign seen[i]  = seen[i-1] | req[i-1];
      assign grant[i] = req[i] & ~seen[i];
    end
  endgenerate

  assign any = |req;

  always_comb
  begin
    vec_num = 5'h00;
    for (int k = 0; k < 16; k++)
      if (grant[k])
        vec_num = 5'(k + 1);
  end

endmodule // irq_priority_pick

// >>> testbench/irq_source_model.sv
// far-side model: drives one active-low interrupt pin with a chosen low-phase length
`timescale 1ns/1ps

module irq_source_model
(
  // clock
  input  wire logic       core_clk,
  // command
  input  wire logic       go,
  input  wire logic [2:0] lo_len,
  // pin and status
  output logic            pin_n,
  output logic            busy
);
  // ==================================================================
  // pulse generator
  // idle level is high, so the high phase before each low phase is long
  initial
  begin
    pin_n = 1'b1;
    busy  = 1'b0;
    forever
    begin
      @(posedge go);
      busy = 1'b1;
      @(posedge core_clk);
      #5 pin_n = 1'b0;
      repeat (lo_len) @(posedge core_clk);
      #5 pin_n = 1'b1;
      busy = 1'b0;
    end
  end
endmodule // irq_source_model

// >>> testbench/test_cpu_interrupt_controller.sv
// self-checking testbench of the interrupt controller
`timescale 1ns/1ps
`include "irq_ctrl_defines.svh"

module test_cpu_interrupt_controller;
  // ==================================================================
  // signals
  logic        core_clk, rst_n, ext_irq_one, ext_irq_two, ext_irq_three, ext_irq_four;
  logic        nmi_in_n, timer_irq, serial_rx_irq, serial_tx_irq, second_port_rx_irq;
  logic        second_port_tx_irq, host_port_irq, serial_port_active, dm_wr, dm_rd;
  logic        boundary_ok, deep_idle_state, idle_state, set_disable_instr;
  logic        clear_disable_instr, enable_return_instr, plain_irq_return_instr, nmi_instr;
  logic        trap_instr, software_irq_instr, page_ptr_wr, bus_hold, hold_mode_bit;
  logic        global_disable_bit_r, vector_load_r, pc_push_r, shadow_save_r, go, busy;
  logic        shadow_restore_r, acknowledge_out_n_r, ack_addr_drive_r, wake_req_r;
  logic [2:0]  lo_len;
  logic [4:0]  software_irq_num, page_ptr_wdata, vector_page_pointer_r, ack_addr_r;
  logic [15:0] dm_addr, dm_wdata, dm_rdata_r, vector_addr_r, rv;
  int          fails, check_count, n;

  // ==================================================================
  // design and far side
  cpu_interrupt_controller i_cpu_interrupt_controller (.core_clk, .rst_n, .ext_irq_one,
    .ext_irq_two, .ext_irq_three, .ext_irq_four, .nmi_in_n, .timer_irq, .serial_rx_irq,
    .serial_tx_irq, .second_port_rx_irq, .second_port_tx_irq, .host_port_irq,
    .serial_port_active, .dm_addr, .dm_wr, .dm_rd, .dm_wdata, .dm_rdata_r, .boundary_ok,
    .deep_idle_state, .idle_state, .set_disable_instr, .clear_disable_instr,
    .enable_return_instr, .plain_irq_return_instr, .nmi_instr, .trap_instr,
    .software_irq_instr, .software_irq_num, .page_ptr_wr, .page_ptr_wdata, .bus_hold,
    .hold_mode_bit, .global_disable_bit_r, .vector_page_pointer_r, .vector_addr_r,
    .vector_load_r, .pc_push_r, .shadow_save_r, .shadow_restore_r, .acknowledge_out_n_r,
    .ack_addr_r, .ack_addr_drive_r, .wake_req_r);

  irq_source_model i_irq_source_model (.core_clk, .go, .lo_len, .pin_n(ext_irq_one), .busy);

  // ==================================================================
  // helpers
  task automatic cyc;
    @(posedge core_clk);
    #5;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    dm_addr = a;
    dm_wdata = d;
    dm_wr = 1'b1;
    cyc;
    dm_wr = 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a);
    dm_addr = a;
    dm_rd = 1'b1;
    cyc;
    dm_rd = 1'b0;
    rv = dm_rdata_r;
  endtask

  task automatic serve(input logic [4:0] num, input logic [15:0] va, input logic drv,
                       input logic sv);
    n = 0;
    while (acknowledge_out_n_r !== 1'b0 && n < 20)
    begin
      cyc;
      n++;
    end
    check({15'h0, acknowledge_out_n_r}, 16'h0000);
    check({11'h0, ack_addr_r}, {11'h0, num});
    check(vector_addr_r, va);
    check({15'h0, ack_addr_drive_r}, {15'h0, drv});
    check({15'h0, global_disable_bit_r}, 16'h0001);
    check({14'h0, vector_load_r, pc_push_r}, 16'h0003);
    check({15'h0, shadow_save_r}, {15'h0, sv});
  endtask

  task automatic enable_all;
    clear_disable_instr = 1'b1;
    cyc;
    clear_disable_instr = 1'b0;
  endtask

  // ==================================================================
  // scenarios
  task automatic t_registers;
    check({15'h0, global_disable_bit_r}, 16'h0001);
    check(vector_addr_r, 16'h0000);
    check({11'h0, vector_page_pointer_r}, 16'h0000);
    rd(`MASK_REG_ADDR);
    check(rv, 16'h0000);
    wr(`MASK_REG_ADDR, 16'hFFFF);
    rd(`MASK_REG_ADDR);
    check(rv, 16'h09FF);
    rd(16'h0008);
    check(rv, 16'h0000);
    wr(`MASK_REG_ADDR, 16'h0000);
  endtask

  // low phase one short of, then equal to, the minimum in both modes
  task automatic t_pins;
    for (int i = 0; i < 4; i++)
    begin
      wr(`FLAG_REG_ADDR, 16'hFFFF);
      deep_idle_state = i[1];
      lo_len = 3'(2 + i);
      go = 1'b1;
      cyc;
      go = 1'b0;
      n = 0;
      while (busy && n < 20)
      begin
        cyc;
        n++;
      end
      repeat (4) cyc;
      rd(`FLAG_REG_ADDR);
      check(rv, {15'h0, i[0]});
    end
    deep_idle_state = 1'b0;
    wr(`FLAG_REG_ADDR, 16'hFFFF);
  endtask

  task automatic t_service;
    timer_irq = 1'b1;
    host_port_irq = 1'b1;
    cyc;
    timer_irq = 1'b0;
    host_port_irq = 1'b0;
    cyc;
    rd(`FLAG_REG_ADDR);
    check(rv, 16'h0808);
    wr(`MASK_REG_ADDR, 16'h0808);
    page_ptr_wdata = 5'h01;
    page_ptr_wr = 1'b1;
    cyc;
    page_ptr_wr = 1'b0;
    check({11'h0, vector_page_pointer_r}, 16'h0001);
    enable_all;
    serve(5'h04, 16'h0808, 1'b1, 1'b1);
    cyc;
    rd(`FLAG_REG_ADDR);
    check(rv, 16'h0800);
    enable_all;
    serve(5'h0C, 16'h0818, 1'b1, 1'b1);
    timer_irq = 1'b1;
    cyc;
    timer_irq = 1'b0;
    repeat (6)
    begin
      cyc;
      check({15'h0, acknowledge_out_n_r}, 16'h0001);
    end
    wr(`FLAG_REG_ADDR, 16'h0000);
    rd(`FLAG_REG_ADDR);
    check(rv, 16'h0008);
    bus_hold = 1'b1;
    trap_instr = 1'b1;
    cyc;
    trap_instr = 1'b0;
    serve(5'h11, 16'h0822, 1'b0, 1'b0);
    bus_hold = 1'b0;
  endtask

  // idle wake while disabled, nonmaskable, return, active serial port, software line
  task automatic t_nonmask;
    idle_state = 1'b1;
    cyc;
    idle_state = 1'b0;
    check({15'h0, wake_req_r}, 16'h0001);
    rd(`FLAG_REG_ADDR);
    check(rv, 16'h0008);
    nmi_instr = 1'b1;
    cyc;
    nmi_instr = 1'b0;
    serve(5'h12, 16'h0824, 1'b1, 1'b0);
    enable_return_instr = 1'b1;
    cyc;
    enable_return_instr = 1'b0;
    check({15'h0, shadow_restore_r}, 16'h0001);
    check({15'h0, global_disable_bit_r}, 16'h0000);
    serve(5'h04, 16'h0808, 1'b1, 1'b1);
    serial_port_active = 1'b1;
    serial_rx_irq = 1'b1;
    cyc;
    serial_rx_irq = 1'b0;
    wr(`MASK_REG_ADDR, 16'h0010);
    enable_all;
    serve(5'h05, 16'h080A, 1'b1, 1'b1);
    cyc;
    rd(`FLAG_REG_ADDR);
    check(rv, 16'h0010);
    software_irq_num = 5'h01;
    software_irq_instr = 1'b1;
    cyc;
    software_irq_instr = 1'b0;
    serve(5'h01, 16'h0802, 1'b1, 1'b1);
    serial_port_active = 1'b0;
  endtask

  // ==================================================================
  // closing
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // the whole run needs under 150 cycles; the limit of 4000 cycles allows over 25 times that
  initial
  begin
    #200000;
    fails++;
    report_and_stop;
  end

  initial
  begin
    {dm_wr, dm_rd, timer_irq, serial_rx_irq, serial_tx_irq, second_port_rx_irq} = '0;
    {second_port_tx_irq, host_port_irq, serial_port_active, deep_idle_state, idle_state} = '0;
    {set_disable_instr, clear_disable_instr, enable_return_instr, nmi_instr, go} = '0;
    {plain_irq_return_instr, trap_instr, software_irq_instr, page_ptr_wr, bus_hold} = '0;
    {ext_irq_two, ext_irq_three, ext_irq_four, nmi_in_n, boundary_ok} = '1;
    hold_mode_bit = 1'b0;
    software_irq_num = 5'h00;
    page_ptr_wdata = 5'h00;
    lo_len = 3'h0;
    dm_addr = 16'h0000;
    dm_wdata = 16'h0000;
    rst_n = 1'b0;
    repeat (12) @(posedge core_clk);
    #5 rst_n = 1'b1;
    cyc;
    t_registers;
    t_pins;
    t_service;
    t_nonmask;
    report_and_stop;
  end
endmodule // test_cpu_interrupt_controller
